// [hdl/lsw_divider.sv]
`timescale 1ns/10ps
`default_nettype none

// turns edges of the chosen measurement clock into one tick per divided half-period
module lsw_divider (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // measurement clock as a sampled level
  input wire logic src_level,
  // edges needed per tick, minus one
  input wire logic [2:0] edges_minus_one,
  // one tick per half-period of the divided clock
  output logic half_tick
);
  import lsw_pkg::*;

  typedef struct packed {
    logic last_level;
    logic [2:0] edge_cnt;
    logic tick;
  } lsw_div_state_t;

  lsw_div_state_t state;
  lsw_div_state_t next_state;
  logic src_edge;

  assign half_tick = state.tick;

  // both edges count, so the divided half-period spans divisor source half-periods
  always_comb begin
    next_state = state;
    src_edge = src_level ^ state.last_level;
    next_state.last_level = src_level;
    next_state.tick = 1'b0;
    if (src_edge) begin
      if (state.edge_cnt >= edges_minus_one) begin
        next_state.edge_cnt = LSW_DIV_CNT_ZERO;
        next_state.tick = 1'b1;
      end else begin
        next_state.edge_cnt = state.edge_cnt + LSW_DIV_CNT_ONE;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

endmodule

`default_nettype wire

// [hdl/lsw_pkg.sv]
package lsw_pkg;

  // register map of the management port (register addresses)
  localparam logic [15:0] LSW_ADDR_CONTROL = 16'h8040;
  localparam logic [15:0] LSW_ADDR_STATUS = 16'h8041;
  localparam logic [15:0] LSW_ADDR_COUNT_LO = 16'h8042;
  localparam logic [15:0] LSW_CONTROL_RESET = 16'h0000;
  localparam logic [15:0] LSW_CONTROL_MASK = 16'h00FF;

  // control field positions
  localparam int LSW_STOP_SEL_LSB = 6;
  localparam int LSW_DIV_LSB = 4;
  localparam int LSW_START_SEL_LSB = 2;
  localparam int LSW_DIV_GATE_BIT = 2;
  localparam int LSW_ENABLE_BIT = 1;
  localparam int LSW_CLK_SRC_BIT = 0;

  // status field positions
  localparam int LSW_ST_START_LSB = 12;
  localparam int LSW_ST_STOP_LSB = 8;
  localparam int LSW_ST_VALID_BIT = 4;

  // counter geometry
  localparam int LSW_COUNT_W = 20;
  localparam logic [19:0] LSW_COUNT_ZERO = 20'h00000;
  localparam logic [19:0] LSW_COUNT_MAX = 20'hFFFFF;
  localparam logic [19:0] LSW_COUNT_ONE = 20'h00001;

  // divider: divide by 1, 2, 4, 8 -> edges per counted half-period
  localparam logic [1:0] LSW_DIV_BY1 = 2'h0;
  localparam logic [2:0] LSW_DIV_CNT_ONE = 3'h1;
  localparam logic [2:0] LSW_DIV_CNT_ZERO = 3'h0;

  // start and stop point selections
  localparam logic [1:0] LSW_SEL_LOW_SPEED = 2'h0;
  localparam logic [1:0] LSW_SEL_HIGH_SPEED = 2'h1;

  // stopwatch states, one-hot
  typedef enum logic [2:0] {
    LSW_ARMED = 3'h1,
    LSW_COUNTING = 3'h2,
    LSW_DONE = 3'h4
  } lsw_state_t;

  // control register fields
  typedef struct packed {
    logic [7:0] unused;
    logic [1:0] stop_point_select;
    logic [1:0] measure_clock_divider;
    logic [1:0] start_point_select;
    logic stopwatch_enable;
    logic measure_clock_source;
  } lsw_control_t;

  // management port request
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic write;
    logic read;
  } lsw_req_t;

  // comma events from the data paths
  typedef struct packed {
    logic [3:0] ls_tx_comma;
    logic [1:0] hs_rx_comma;
    logic [3:0] ls_rx_comma;
    logic [1:0] hs_tx_comma;
  } lsw_events_t;

endpackage

// [hdl/lsw_stopwatch.sv]
`timescale 1ns/10ps
`default_nettype none

module lsw_stopwatch (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // management register port
  input wire lsw_pkg::lsw_req_t req,
  output logic [15:0] rdata,
  output logic rvalid,
  // measurement clocks as sampled levels
  input wire logic vco_clock_level,
  input wire logic recovered_byte_clock_level,
  // comma events and the marker pin
  input wire lsw_pkg::lsw_events_t events,
  input wire logic external_marker_pin,
  // status
  output logic result_valid_flag
);
  import lsw_pkg::*;

  // all state of the block outside the divider in one record; the comb block builds the next copy
  typedef struct packed {
    lsw_control_t control;
    lsw_state_t fsm;
    logic [19:0] elapsed_cycle_count;
    logic [3:0] start_found;
    logic [3:0] stop_found;
    logic valid;
    logic marker_last;
    logic [15:0] rdata;
    logic rvalid;
  } lsw_top_state_t;

  // nets between the divider, the event pickers and the register port
  lsw_top_state_t state;
  lsw_top_state_t next_state;
  logic half_tick;
  logic src_level;
  logic [2:0] edges_minus_one;
  logic marker_rise;
  logic [3:0] start_hits;
  logic [3:0] stop_hits;
  logic clear_read;
  logic [19:0] shown_count;

  // map a point selection to the hits it watches; the pin wins for any 1x code
  // a 1x code ignores the low bit, so 10 and 11 both pick the marker pin
  function automatic logic [3:0] point_hits(input logic [1:0] sel, input logic [3:0] low_speed,
                                            input logic [1:0] high_speed, input logic marker);
    logic [3:0] hits;
    hits = 4'h0;
    if (sel[1]) begin
      hits = {3'h0, marker};
    end else if (sel == LSW_SEL_HIGH_SPEED) begin
      hits = {2'h0, high_speed};
    end else begin
      hits = low_speed;
    end
    return hits;
  endfunction

  // divider setting is forced to 1 when control bit 2 is set
  // edges per tick minus one is a run of low ones: 0, 1, 3 or 7; built as a
  // shifted mask so the divide-by-8 case needs no wrap-around arithmetic
  function automatic logic [2:0] divide_edges(input lsw_control_t ctl);
    logic [1:0] div;
    logic [2:0] all_ones;
    all_ones = ~LSW_DIV_CNT_ZERO;
    div = ctl[LSW_DIV_GATE_BIT] ? LSW_DIV_BY1 : ctl.measure_clock_divider;
    return ~(all_ones << div);
  endfunction

  // the count shows only once a measurement has completed; an early read sees
  // zero, so a running value is never mistaken for a result
  function automatic logic [19:0] count_view(input lsw_top_state_t s);
    logic [19:0] view;
    view = LSW_COUNT_ZERO;
    if (s.valid) begin
      view = s.elapsed_cycle_count;
    end
    return view;
  endfunction

  // status word: start and stop found flags, valid bit, top four count bits
  function automatic logic [15:0] status_word(input lsw_top_state_t s);
    logic [15:0] word;
    logic [19:0] view;
    word = 16'h0000;
    view = count_view(s);
    word[LSW_ST_START_LSB +: 4] = s.start_found;
    word[LSW_ST_STOP_LSB +: 4] = s.stop_found;
    word[LSW_ST_VALID_BIT] = s.valid;
    word[3:0] = view[19:16];
    return word;
  endfunction

  assign rdata = state.rdata;
  assign rvalid = state.rvalid;
  assign result_valid_flag = state.valid;

  // clock source choice; the byte clock passes the same divider as the VCO path,
  // so a source switch mid-run may shift the next tick by a few cycles
  assign src_level = state.control.measure_clock_source ? recovered_byte_clock_level
                                                        : vco_clock_level;
  assign edges_minus_one = divide_edges(state.control);
  // both read paths of the count go through the same early-read mask
  assign shown_count = count_view(state);

  // the divider turns level changes of the chosen clock into counting ticks
  lsw_divider lsw_divider_inst (
    .clock(clock),
    .rst(rst),
    .src_level(src_level),
    .edges_minus_one(edges_minus_one),
    .half_tick(half_tick)
  );

  // the marker pin is a level; only its rising edge is an event, so a pin held
  // high across a clear cannot open a second measurement by itself
  assign marker_rise = external_marker_pin & ~state.marker_last;
  assign start_hits = point_hits(state.control.start_point_select, events.ls_tx_comma,
                                 events.hs_rx_comma, marker_rise);
  assign stop_hits = point_hits(state.control.stop_point_select, events.ls_rx_comma,
                                events.hs_tx_comma, marker_rise);
  assign clear_read = req.read && (req.addr == LSW_ADDR_COUNT_LO);

  // register port, stopwatch sequence and read side effects
  always_comb begin
    next_state = state;
    next_state.marker_last = external_marker_pin;
    next_state.rvalid = req.read;
    next_state.rdata = 16'h0000;

    // control writes; upper byte reserved and reads zero
    // the upper byte is dropped at the write, so it can never read back set
    if (req.write && (req.addr == LSW_ADDR_CONTROL)) begin
      next_state.control = lsw_control_t'(req.wdata & LSW_CONTROL_MASK);
    end

    // reads return registered data one cycle later
    // rdata is zero whenever no read is being answered
    if (req.read) begin
      unique case (req.addr)
        LSW_ADDR_CONTROL: next_state.rdata = state.control;
        LSW_ADDR_STATUS: next_state.rdata = status_word(state);
        LSW_ADDR_COUNT_LO: next_state.rdata = shown_count[15:0];
        default: next_state.rdata = 16'h0000;
      endcase
    end

    // low-word read readies a repeat measurement
    // an early read of the low word also abandons a run that is still counting and re-arms
    if (clear_read) begin
      next_state.elapsed_cycle_count = LSW_COUNT_ZERO;
      next_state.start_found = 4'h0;
      next_state.stop_found = 4'h0;
      next_state.valid = 1'b0;
      next_state.fsm = LSW_ARMED;
    end else begin
      unique case (state.fsm)
        LSW_ARMED: begin
          // counting opens next cycle, so a stop beside the start is not seen
          if (state.control.stopwatch_enable && (start_hits != 4'h0)) begin
            next_state.fsm = LSW_COUNTING;
          end
        end
        LSW_COUNTING: begin
          // dropping enable mid-run abandons the measurement instead of freezing it
          if (!state.control.stopwatch_enable) begin
            next_state.fsm = LSW_ARMED;
            next_state.elapsed_cycle_count = LSW_COUNT_ZERO;
          end else if (stop_hits != 4'h0) begin
            next_state.fsm = LSW_DONE;
            next_state.valid = 1'b1;
          end else if (half_tick && (state.elapsed_cycle_count != LSW_COUNT_MAX)) begin
            // an over-long latency sticks at all ones rather than wrapping
            next_state.elapsed_cycle_count = state.elapsed_cycle_count + LSW_COUNT_ONE;
          end
        end
        LSW_DONE: next_state.fsm = LSW_DONE; // held until the low word is read
        default: next_state.fsm = LSW_ARMED;
      endcase
    end

    // found flags latch; a hit in the clearing cycle is kept, set beats clear
    // flags only latch while enabled, so a disabled block sets no new flags
    if (state.control.stopwatch_enable && (state.fsm == LSW_ARMED)) begin
      next_state.start_found = next_state.start_found | start_hits;
    end
    if (state.control.stopwatch_enable && (state.fsm == LSW_COUNTING)) begin
      next_state.stop_found = next_state.stop_found | stop_hits;
    end
  end

  // synchronous reset: control back to all zeros, stopwatch armed and idle
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= '0;
      state.control <= lsw_control_t'(LSW_CONTROL_RESET);
      state.fsm <= LSW_ARMED;
    end else begin
      state <= next_state;
    end
  end

endmodule

`default_nettype wire

// [tb/lsw_stopwatch_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module lsw_stopwatch_asserts (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register port
  input wire lsw_pkg::lsw_req_t req,
  input wire logic [15:0] rdata,
  input wire logic rvalid,
  // events and status
  input wire lsw_pkg::lsw_events_t events,
  input wire logic external_marker_pin,
  input wire logic result_valid_flag
);
  import lsw_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic lo_rd;
  logic stop_seen;
  // marker edge is found in the same cycle; stop causes are still looked for one or two back
  assign lo_rd = req.read && req.addr == LSW_ADDR_COUNT_LO;
  assign stop_seen = |events.ls_rx_comma || |events.hs_tx_comma || external_marker_pin;
  a_read_answer: assert property (req.read |=> rvalid) else $error("read not answered");
  a_no_stray: assert property (!req.read |=> !rvalid && rdata == 16'h0000) else $error("stray read data");
  a_ctrl_upper: assert property (rvalid && $past(req.addr) == LSW_ADDR_CONTROL |-> rdata[15:8] == 8'h00)
    else $error("control upper byte set");
  a_clear_on_read: assert property (
    lo_rd |=> !result_valid_flag) else $error("valid survived clear");
  a_valid_holds: assert property (
    result_valid_flag && !lo_rd |=> result_valid_flag) else $error("valid dropped");
  a_status_mirror: assert property (
    rvalid && $past(req.addr) == LSW_ADDR_STATUS |-> rdata[4] == $past(result_valid_flag))
    else $error("status valid bit wrong");
  a_valid_cause: assert property (
    $rose(result_valid_flag) |-> $past(stop_seen) || $past(stop_seen, 2)) else $error("valid without stop");
  a_rise_not_clear: assert property (
    $rose(result_valid_flag) |-> !$past(lo_rd)) else $error("valid rose on clear");
  a_count_hidden: assert property (
    rvalid && $past(req.addr) == LSW_ADDR_COUNT_LO && !$past(result_valid_flag) |-> rdata == 16'h0000)
    else $error("count shown before stop");
  cover property (rvalid && $past(req.addr) == LSW_ADDR_COUNT_LO && !$past(result_valid_flag));
  cover property ($rose(result_valid_flag));
  cover property (lo_rd && result_valid_flag);
  cover property (rvalid && $past(req.addr) == LSW_ADDR_STATUS);
endmodule
bind lsw_stopwatch lsw_stopwatch_asserts lsw_stopwatch_asserts_inst (.clock(clock), .rst(rst), .req(req),
  .rdata(rdata), .rvalid(rvalid), .events(events), .external_marker_pin(external_marker_pin),
  .result_valid_flag(result_valid_flag));
`default_nettype wire

// [tb/tb_lsw_stopwatch.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_lsw_stopwatch;
  import lsw_pkg::*;
  logic clock, rst, rvalid, result_valid_flag, vco, rbc, marker;
  logic [15:0] rdata, d;
  logic [19:0] cnt;
  lsw_req_t req;
  lsw_events_t ev;
  lsw_events_t sev [3] = '{12'h100, 12'h040, 12'h000};
  lsw_events_t pev [3] = '{12'h004, 12'h001, 12'h000};
  int err_total, checks_done, cycles, st, sp, dv, src, ex, c, n;
  lsw_stopwatch lsw_stopwatch_inst (.clock(clock), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid),
    .vco_clock_level(vco), .recovered_byte_clock_level(rbc), .events(ev), .external_marker_pin(marker),
    .result_valid_flag(result_valid_flag));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // measurement clocks kept slow so every level change is sampled
  initial begin
    vco = 1'b0;
    forever begin
      repeat (2) @(posedge clock);
      #1 vco = ~vco;
    end
  end
  // byte clock as slow as the slowest divided VCO clock, as software is advised
  initial begin
    rbc = 1'b0;
    forever begin
      repeat (16) @(posedge clock);
      #1 rbc = ~rbc;
    end
  end
  // hang guard, a full run needs about 2340 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(string name, logic [19:0] seen, logic [19:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(logic [15:0] a, logic [15:0] v);
    @(posedge clock);
    #1 req = '{addr: a, wdata: v, write: 1'b1, read: 1'b0};
    @(posedge clock);
    #1 req.write = 1'b0;
  endtask
  task automatic rd(logic [15:0] a);
    @(posedge clock);
    #1 req = '{addr: a, wdata: 16'h0000, write: 1'b0, read: 1'b1};
    @(posedge clock);
    #1 req.read = 1'b0;
    check("rvalid", 20'(rvalid), 20'h1);
    d = rdata;
  endtask
  task automatic pulse(lsw_events_t e, logic m);
    @(posedge clock);
    #1 ev = e;
    marker = m;
    @(posedge clock);
    #1 ev = '0;
    marker = 1'b0;
  endtask
  initial begin
    req = '0;
    ev = '0;
    marker = 1'b0;
    rst = 1'b1;
    repeat (16) @(posedge clock);
    #1 rst = 1'b0;
    rd(LSW_ADDR_CONTROL);
    check("control_reset", 20'(d), 20'h0);
    rd(LSW_ADDR_COUNT_LO);
    check("count_reset", 20'(d), 20'h0);
    wr(LSW_ADDR_CONTROL, 16'hFFFF);
    rd(LSW_ADDR_CONTROL);
    check("control_rw", 20'(d), 20'h000FF);
    rd(16'h8043);
    check("unmapped", 20'(d), 20'h0);
    // disabled stopwatch ignores a start and stop pair
    wr(LSW_ADDR_CONTROL, 16'h0000);
    pulse(sev[0], 1'b0);
    pulse(pev[0], 1'b0);
    repeat (3) @(posedge clock);
    check("valid_off", 20'(result_valid_flag), 20'h0);
    // an early low-word read shows zero and abandons the run back to armed
    wr(LSW_ADDR_CONTROL, 16'h0002);
    pulse(sev[0], 1'b0);
    repeat (20) @(posedge clock);
    rd(LSW_ADDR_COUNT_LO);
    check("count_early", 20'(d), 20'h0);
    pulse(pev[0], 1'b0);
    repeat (2) @(posedge clock);
    check("stop_after_clear", 20'(result_valid_flag), 20'h0);
    rd(LSW_ADDR_STATUS);
    check("status_early", 20'(d), 20'h0);
    $display("test basic done");
    for (n = 0; n < 9; n++) begin
      st = n % 3;
      sp = n / 3;
      src = n % 2;
      // the byte clock runs undivided, keeping the divided clock no slower than it
      dv = src ? 0 : (n / 2) % 4;
      wr(LSW_ADDR_CONTROL, 16'(sp << 6 | dv << 4 | st << 2 | 2 | src));
      pulse(sev[st], st == 2);
      repeat (234) @(posedge clock);
      pulse(12'h005 & ~pev[sp], sp != 2);
      repeat (2) @(posedge clock);
      check("early_stop", 20'(result_valid_flag), 20'h0);
      pulse(pev[sp], sp == 2);
      repeat (2) @(posedge clock);
      check("valid", 20'(result_valid_flag), 20'h1);
      rd(LSW_ADDR_STATUS);
      check("status", 20'({d[15:12] != 0, d[11:8] != 0, d[4]}), 20'h7);
      cnt[19:16] = d[3:0];
      rd(LSW_ADDR_COUNT_LO);
      cnt[15:0] = d;
      // about 240 cycles span, one count per half-period of the divided clock
      ex = 240 / ((src ? 16 : 2) * (st == 1 ? 1 : 1 << dv));
      c = cnt;
      check("count_near", 20'(c >= ex - 2 && c <= ex + 2), 20'h1);
      check("valid_clr", 20'(result_valid_flag), 20'h0);
      rd(LSW_ADDR_STATUS);
      check("status_clr", 20'(d), 20'h0);
      $display("test measure %0d done", n);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
